// >>> src/fsp_defs.vh
/*
  Constants of the flash self-programming controller: register offsets,
  control field positions, key values, operation codes and timing.
  Assumes a 100 MHz system clock and a 32-bit Wishbone register bus.
*/
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// ----------------------------------------------------------------------
// Register word offsets on wb_adr_i[4:2]
// ----------------------------------------------------------------------
`define FSP_ADR_CTRL 3'h0
`define FSP_ADR_KEY 3'h1
`define FSP_ADR_PAGE 3'h2
`define FSP_ADR_EA 3'h3
`define FSP_ADR_LOW 3'h4
`define FSP_ADR_HIGH 3'h5
`define FSP_ADR_STAT 3'h6

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define FSP_CTRL_START 15
`define FSP_CTRL_OP_WRITE_ENABLE 14
`define FSP_CTRL_ERR 13
`define FSP_CTRL_PROGRAM_ONLY_ENABLE 12
`define FSP_CTRL_ERASE 6
`define FSP_CTRL_RESET 16'h0000

// ----------------------------------------------------------------------
// Unlock keys and operation codes
// ----------------------------------------------------------------------
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa
`define FSP_OP_ERASE1 6'h18
`define FSP_OP_ERASE2 6'h19
`define FSP_OP_ERASE4 6'h1a
`define FSP_OP_PROG_HI 4'h1
`define FSP_ERASED_WORD 24'hffffff

// ----------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------
`define FSP_ROW_WORDS 32
`define FSP_ROW_BITS_IN 5
`define FSP_OP_TIME_NS 2000
`define FSP_CLK_PERIOD_NS 10
`define FSP_OP_CYCLES (`FSP_OP_TIME_NS / `FSP_CLK_PERIOD_NS)

`endif

// >>> src/fsp_flash_self_program_control.v
/*
  Run-time self-programming controller: holding latches, table address
  formation, unlock key check, control register and timed program/erase
  of a small on-chip program array.
  Assumes a classic Wishbone master on the same clock and a processor
  that honours cpu_stall_o.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"

// Operation
// - Array is organised in rows of 32 instruction words (96 bytes).
// - Erase covers one, two or four rows; programming covers one row.
// - Low two operation select bits choose erase block size.
// - A single program word may be programmed on its own.
// - Erase and write blocks align to their size; low address bits ignored.
// - Table writes only fill holding latches, committed when programming runs.
// - Programming succeeds with any number of prior latch writes.
// - Latches accept any order and rewrites; last write wins.
// - A latch write completes as a single word in two cycles.
// - Target address is table page concatenated with 16-bit effective address.
// - Low accesses bits 15..0, high accesses 23..16; word and byte sizes.
// - Unlock register is write-only; 55h then AAh must precede a start.
// - Start bit begins the selected operation; hardware clears it when done.
// - Processor is stalled while an operation runs, released on completion.
// - Software can only set the start bit; reset value zero.
// - Control bits 11..7 read zero; implemented bits reset to zero.
// - Write-enable bit 14 gates every program and erase launch.
// - Sequence error bit 13 set on improper start, zero after normal completion.
// - Erase bit 6 selects erase or program on the next start.
// - Codes 011000/011001/011010 erase 1/2/4 rows, 0001xx programs; others nothing.
module fsp_flash_self_program_control #(
  parameter ROW_BITS = 3,
  parameter OP_CYCLES = `FSP_OP_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:2] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg cpu_stall_o
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam AW = ROW_BITS + `FSP_ROW_BITS_IN;
  localparam WORDS = 1 << AW;
  localparam NL = `FSP_ROW_WORDS;
  localparam [ROW_BITS-1:0] ROW_ALL = {ROW_BITS{1'b1}};

  localparam KEY_IDLE = 2'h0;
  localparam KEY_HALF = 2'h1;
  localparam KEY_ARMED = 2'h2;

  localparam OPK_NONE = 2'h0;
  localparam OPK_ERASE = 2'h1;
  localparam OPK_PROG = 2'h2;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg [23:0] flash_mem [0:WORDS-1];
  reg [23:0] latch_reg [0:NL-1];
  reg [NL-1:0] latch_valid_reg;

  // ----------------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------------
  reg [15:0] flash_op_control_reg;
  reg [7:0] table_page_reg;
  reg [15:0] effective_address_reg;
  reg [1:0] key_state_reg;
  reg busy_reg;
  reg wait_reg;
  reg [15:0] count_reg;
  reg [1:0] op_kind_reg;
  reg [1:0] op_size_reg;
  reg [23:0] op_addr_reg;

  // ----------------------------------------------------------------------
  // Address formation and request decode
  // ----------------------------------------------------------------------
  wire [23:0] table_addr = {table_page_reg, effective_address_reg};
  wire [AW-1:0] word_idx = table_addr[AW:1];
  wire [4:0] latch_idx = table_addr[5:1];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire latch_wr = wb_we_i & ((wb_adr_i == `FSP_ADR_LOW) | (wb_adr_i == `FSP_ADR_HIGH));
  // A latch write holds one wait state, so it completes in two cycles.
  wire take = req & ~busy_reg & (~latch_wr | wait_reg);
  wire wr_take = take & wb_we_i;
  wire ctrl_wr = wr_take & (wb_adr_i == `FSP_ADR_CTRL);

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  wire start_try = ctrl_wr & wb_sel_i[1] & wb_dat_i[`FSP_CTRL_START];
  wire [5:0] op_sel = wb_dat_i[5:0];
  wire erase_sel = wb_dat_i[`FSP_CTRL_ERASE];
  wire op_prog = ~erase_sel &
                 (op_sel[5:2] == `FSP_OP_PROG_HI);
  wire start_ok = start_try & (key_state_reg == KEY_ARMED) &
                  wb_dat_i[`FSP_CTRL_OP_WRITE_ENABLE] & wb_sel_i[0];
  wire done = busy_reg & (count_reg == 16'h0000);

  reg [1:0] op_kind_next;
  always @* begin
    op_kind_next = OPK_NONE;
    case (op_sel)
      `FSP_OP_ERASE1: op_kind_next = erase_sel ? OPK_ERASE : OPK_NONE;
      `FSP_OP_ERASE2: op_kind_next = erase_sel ? OPK_ERASE : OPK_NONE;
      `FSP_OP_ERASE4: op_kind_next = erase_sel ? OPK_ERASE : OPK_NONE;
      default: op_kind_next = op_prog ? OPK_PROG : OPK_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    case (wb_adr_i)
      `FSP_ADR_CTRL: rd_next = {16'h0000, flash_op_control_reg[15:12], 5'h00,
                                flash_op_control_reg[6:0]};
      `FSP_ADR_KEY: rd_next = 32'h00000000;
      `FSP_ADR_PAGE: rd_next = {24'h000000, table_page_reg};
      `FSP_ADR_EA: rd_next = {16'h0000, effective_address_reg};
      `FSP_ADR_LOW: rd_next = {16'h0000, flash_mem[word_idx][15:0]};
      `FSP_ADR_HIGH: rd_next = {24'h000000, flash_mem[word_idx][23:16]};
      `FSP_ADR_STAT: rd_next = {29'h00000000, (key_state_reg == KEY_ARMED), busy_reg,
                                wait_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus slave, key check and control register
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      wait_reg <= 1'b0;
      table_page_reg <= 8'h00;
      effective_address_reg <= 16'h0000;
      key_state_reg <= KEY_IDLE;
    end else begin
      wb_ack_o <= take;
      wb_dat_o <= (take & ~wb_we_i) ? rd_next : 32'h00000000;
      wait_reg <= req & ~busy_reg & latch_wr & ~wait_reg;
      if (wr_take) begin
        // Any write that is not the next key step drops the unlock.
        // Reads leave the sequence alone, so polling between the keys is harmless.
        if (wb_adr_i == `FSP_ADR_KEY && wb_sel_i[0] && wb_dat_i[7:0] == `FSP_KEY_FIRST)
          key_state_reg <= KEY_HALF;
        else if (wb_adr_i == `FSP_ADR_KEY && wb_sel_i[0] &&
                 wb_dat_i[7:0] == `FSP_KEY_SECOND && key_state_reg == KEY_HALF)
          key_state_reg <= KEY_ARMED;
        else
          key_state_reg <= KEY_IDLE;
      end
      if (wr_take && wb_adr_i == `FSP_ADR_PAGE && wb_sel_i[0])
        table_page_reg <= wb_dat_i[7:0];
      if (wr_take && wb_adr_i == `FSP_ADR_EA) begin
        if (wb_sel_i[0])
          effective_address_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          effective_address_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Every start attempt flags an error; a finish or a non-start control write of bit 13 low clears it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_op_control_reg <= `FSP_CTRL_RESET;
    end else if (ctrl_wr) begin
      if (wb_sel_i[0])
        flash_op_control_reg[6:0] <= wb_dat_i[6:0];
      if (wb_sel_i[1])
        flash_op_control_reg[14:12] <= wb_dat_i[14:12];
      if (start_try) begin
        flash_op_control_reg[`FSP_CTRL_ERR] <= 1'b1;
        if (start_ok)
          flash_op_control_reg[`FSP_CTRL_START] <= 1'b1;
      end
    end else if (done) begin
      flash_op_control_reg[`FSP_CTRL_START] <= 1'b0;
      flash_op_control_reg[`FSP_CTRL_ERR] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Operation timer
  // ----------------------------------------------------------------------
  // A start cannot meet a completion in one cycle: the bus is held off while busy.
  // The timer counts clocks, so OP_CYCLES must follow any change of clock rate.
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      cpu_stall_o <= 1'b0;
      count_reg <= 16'h0000;
      op_kind_reg <= OPK_NONE;
      op_size_reg <= 2'h0;
      op_addr_reg <= 24'h000000;
    end else if (start_ok && !busy_reg) begin
      busy_reg <= 1'b1;
      cpu_stall_o <= 1'b1;
      count_reg <= OP_CYCLES[15:0] - 16'h0001;
      op_kind_reg <= op_kind_next;
      op_size_reg <= op_sel[1:0];
      op_addr_reg <= table_addr;
    end else if (done) begin
      busy_reg <= 1'b0;
      cpu_stall_o <= 1'b0;
      op_kind_reg <= OPK_NONE;
    end else if (busy_reg) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Holding latches
  // ----------------------------------------------------------------------
  // Rows are only written through the latches; a partly loaded set still
  // commits, and untouched words of the row are left alone.
  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : g_latch
      wire hit = wr_take & latch_wr & (latch_idx == g);
      always @(posedge clk_i) begin
        if (rst_i) begin
          latch_reg[g] <= `FSP_ERASED_WORD;
          latch_valid_reg[g] <= 1'b0;
        end else if (hit) begin
          if (wb_adr_i == `FSP_ADR_LOW) begin
            if (wb_sel_i[0])
              latch_reg[g][7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              latch_reg[g][15:8] <= wb_dat_i[15:8];
          end else if (wb_sel_i[0]) begin
            latch_reg[g][23:16] <= wb_dat_i[7:0];
          end
          latch_valid_reg[g] <= 1'b1;
        end else if (done && op_kind_reg == OPK_PROG) begin
          latch_valid_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Array commit
  // ----------------------------------------------------------------------
  // The array has no reset; software must erase a block before trusting it.
  wire [ROW_BITS-1:0] tgt_row = op_addr_reg[AW:`FSP_ROW_BITS_IN+1];
  reg [ROW_BITS-1:0] row_mask;
  always @* begin
    row_mask = ROW_ALL;
    case (op_size_reg)
      2'h1: row_mask = {{(ROW_BITS-1){1'b1}}, 1'b0};
      2'h2: row_mask = {{(ROW_BITS-2){1'b1}}, 2'h0};
      default: row_mask = ROW_ALL;
    endcase
  end

  generate
    for (g = 0; g < WORDS; g = g + 1) begin : g_word
      localparam [31:0] GIDX = g;
      wire [ROW_BITS-1:0] row_of = GIDX[AW-1:`FSP_ROW_BITS_IN];
      wire [4:0] col = GIDX[4:0];
      wire erase_hit = (op_kind_reg == OPK_ERASE) &
                       ((row_of & row_mask) == (tgt_row & row_mask));
      wire prog_hit = (op_kind_reg == OPK_PROG) & (row_of == tgt_row) &
                      latch_valid_reg[col];
      always @(posedge clk_i) begin
        if (done && erase_hit)
          flash_mem[g] <= `FSP_ERASED_WORD;
        else if (done && prog_hit)
          flash_mem[g] <= latch_reg[col];
      end
    end
  endgenerate

endmodule // fsp_flash_self_program_control

`default_nettype wire

// >>> test/fsp_checker.sv
/*
  Concurrent checks on the ports of the flash self-programming controller.
  Assumes one clock, synchronous active-high reset, bound by module name.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_checker #(
  parameter OP_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpu_stall_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A stall that outlives the timer means the completion never lands.
  int scnt;
  always_ff @(posedge clk_i) begin
    scnt <= (rst_i || !cpu_stall_o) ? 0 : scnt + 1;
  end
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_read_one_cycle: assert property ($rose(wb_stb_i) && wb_cyc_i && !wb_we_i
    && !cpu_stall_o |=> wb_ack_o) else $error("read ack late");
  a_latch_two_cycles: assert property ($rose(wb_stb_i) && wb_cyc_i && wb_we_i
    && wb_adr_i[4:3] == 2'b10 && !cpu_stall_o |=> !wb_ack_o ##1 wb_ack_o)
    else $error("latch write ack timing");
  a_stall_bounded: assert property (scnt <= OP_CYCLES + 2)
    else $error("stall too long");
  a_no_ack_stall: assert property (cpu_stall_o |=> !wb_ack_o)
    else $error("ack while stalled");
  a_ctrl_unused_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 3'h0
    |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[11:7] == 5'h0) else $error("ctrl pad bits");
  a_key_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 3'h1
    |-> wb_dat_o == 32'h0) else $error("key readable");
  a_high_phantom: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 3'h5
    |-> wb_dat_o[31:8] == 24'h0) else $error("high read pad bits");
  c_op_done: cover property ($fell(cpu_stall_o));
  c_key_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == 3'h1);
  c_low_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 3'h4);
endmodule // fsp_checker
bind fsp_flash_self_program_control fsp_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cpu_stall_o(cpu_stall_o));
`default_nettype wire

// >>> test/fsp_cpu_model.sv
/*
  Processor side model: classic single Wishbone cycles on request.
  Assumes the controller acks every request; the bench bounds waits.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [4:2] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  logic [3:0] sel_v = 4'hf;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  task automatic xfer(input logic w, input logic [2:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, sel_v, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    // Released lines carry garbage so nothing leans on stale values.
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
  endtask
endmodule // fsp_cpu_model
`default_nettype wire

// >>> test/tb.sv
/*
  Self-checking bench with an array and latch model of the controller.
  Assumes the controller built with a short operation timer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, stall;
  logic [4:2] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, t;
  integer fails = 0, check_count = 0, seed = 32'hb6ec4180, k, j;
  logic [23:0] mem [0:255];
  logic [23:0] lat [0:31];
  logic lv [0:31];
  logic [2:0] r;
  always #5 clk_i = ~clk_i;
  fsp_cpu_model u_cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  fsp_flash_self_program_control #(.OP_CYCLES(4)) i_fsp_flash_self_program_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_stall_o(stall));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    u_cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a);
    u_cpu.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic lat_wr(input logic [8:0] ea, input logic [23:0] d);
    wr(`FSP_ADR_EA, {23'h0, ea});
    wr(`FSP_ADR_LOW, {16'h0, d[15:0]});
    wr(`FSP_ADR_HIGH, {24'h0, d[23:16]});
    lat[ea[5:1]] = d;
    lv[ea[5:1]] = 1'b1;
  endtask
  task automatic op(input logic [5:0] code, input logic er, input logic [8:0] ea,
                    input logic key_ok, input logic en);
    logic [31:0] cv;
    logic go;
    integer n, i;
    cv = {17'h0, en, 7'h0, er, code};
    go = key_ok & en;
    wr(`FSP_ADR_PAGE, $random(seed) & 32'hff);
    wr(`FSP_ADR_EA, {23'h0, ea});
    wr(`FSP_ADR_CTRL, cv);
    wr(`FSP_ADR_KEY, 32'h55);
    if (!key_ok) wr(`FSP_ADR_PAGE, 32'h0);
    wr(`FSP_ADR_KEY, 32'haa);
    wr(`FSP_ADR_CTRL, cv | 32'h8000);
    @(posedge clk_i);
    #1 chk({31'h0, stall}, {31'h0, go});
    rd(`FSP_ADR_CTRL);
    chk(q, go ? cv : cv | 32'h2000);
    n = code == 6'h18 ? 1 : code == 6'h19 ? 2 : code == 6'h1a ? 4 : 0;
    if (go && er && n > 0)
      for (i = 0; i < n * 32; i++) mem[(ea[8:6] / n) * n * 32 + i] = 24'hffffff;
    if (go && !er && code[5:2] == 4'h1)
      for (i = 0; i < 32; i++) if (lv[i]) begin
        mem[{ea[8:6], i[4:0]}] = lat[i];
        lv[i] = 1'b0;
      end
  endtask
  task automatic row_chk(input logic [2:0] rw);
    integer i;
    logic [15:0] lo;
    for (i = 0; i < 32; i++) begin
      wr(`FSP_ADR_EA, {23'h0, rw, i[4:0], 1'b0});
      rd(`FSP_ADR_LOW);
      lo = q[15:0];
      rd(`FSP_ADR_HIGH);
      chk({8'h0, q[7:0], lo}, {8'h0, mem[{rw, i[4:0]}]});
    end
  endtask
  task automatic end_of_test;
    $display("fails=%0d checks=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #600000;
    fails++;
    end_of_test;
  end
  initial begin
    for (k = 0; k < 32; k++) lv[k] = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`FSP_ADR_CTRL);
    chk(q, 32'h0);
    rd(`FSP_ADR_KEY);
    chk(q, 32'h0);
    op(6'h1a, 1'b1, 9'h00a, 1'b1, 1'b1);
    op(6'h1a, 1'b1, 9'h13c, 1'b1, 1'b1);
    for (k = 0; k < 4; k++) begin
      t = $random(seed);
      r = t[2:0];
      for (j = 0; j < 40; j++) begin
        t = $random(seed);
        lat_wr({r, t[5:1], 1'b0}, t[31:8]);
      end
      op(6'h18, 1'b1, {r, 6'h00}, 1'b1, 1'b1);
      op({4'h1, k[1:0]}, 1'b0, {r, t[7:2]}, 1'b1, 1'b1);
      row_chk(r);
    end
    op(6'h18, 1'b1, {r, 6'h2a}, 1'b1, 1'b1);
    row_chk(r);
    op(6'h19, 1'b1, {r ^ 3'h1, 6'h12}, 1'b1, 1'b1);
    row_chk(r);
    row_chk(r ^ 3'h1);
    lat_wr(9'h09c, 24'h5a3c69);
    op(6'h04, 1'b0, 9'h080, 1'b0, 1'b1);
    op(6'h04, 1'b0, 9'h080, 1'b1, 1'b0);
    op(6'h04, 1'b1, 9'h080, 1'b1, 1'b1);
    op(6'h3f, 1'b1, 9'h080, 1'b1, 1'b1);
    row_chk(3'h2);
    op(6'h18, 1'b1, 9'h080, 1'b1, 1'b1);
    lat_wr(9'h0a0, 24'h123456);
    u_cpu.sel_v = 4'h2;
    wr(`FSP_ADR_LOW, 32'h0000ab00);
    u_cpu.sel_v = 4'hf;
    lat[5'h10][15:8] = 8'hab;
    op(6'h04, 1'b0, 9'h0be, 1'b1, 1'b1);
    row_chk(3'h2);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
